/* File: core/eep_defs.vh */
/*
 * Shared constants of the two-wire serial EEPROM target: bus codes, array
 * geometry, byte kinds and the self-timed programming time.
 * Assumes inclusion by bare name from the design files under core/.
 */
`ifndef EEP_DEFS_VH
`define EEP_DEFS_VH

// Address byte layout.
`define EEP_DEV_CODE 4'hA
`define EEP_RW_BIT 0
`define EEP_A8_BIT 1
`define EEP_CODE_MSB 7
`define EEP_CODE_LSB 4
`define EEP_CS_MSB 3
`define EEP_CS_LSB 2
`define EEP_WADDR_W 8

// Array geometry: 512 bytes in rows of sixteen.
`define EEP_ADDR_W 9
`define EEP_DEPTH 512
`define EEP_COL_W 4
`define EEP_ROW_W 5
`define EEP_PAGE_BYTES 16

// Bit and byte counting.
`define EEP_BITS_PER_BYTE 4'h8
`define EEP_CNT_ZERO 4'h0
`define EEP_CNT_ONE 4'h1

// Kind of the byte being received.
`define EEP_KIND_DEV 2'h0
`define EEP_KIND_WADDR 2'h1
`define EEP_KIND_DATA 2'h2

// Self-timed programming time and the reference clock rate.
`define EEP_PROG_TIME_MS 5
`define EEP_CLK_MHZ 125
// The programming time in reference clock cycles, 625000, sized to the timer.
`define EEP_PROG_CYC 20'h98968
`define EEP_TMR_W 20

`endif

/* File: core/eep_mem.v */
/*
 * Byte array of the EEPROM with one write port and a registered read port.
 * Assumes a single clock; the array content has no reset.
 */
`include "eep_defs.vh"

module eep_mem (
    // Clock and reset.
    input wire i_ref_clk,
    input wire i_rst_b,
    // Write port.
    input wire i_we,
    input wire [`EEP_ADDR_W-1:0] i_waddr,
    input wire [7:0] i_wdata,
    // Read port.
    input wire [`EEP_ADDR_W-1:0] i_raddr,
    output reg [7:0] o_rdata
);

    reg [7:0] mem_ff [0:`EEP_DEPTH-1];

    always @(posedge i_ref_clk) begin
        if (i_we) begin
            mem_ff[i_waddr] <= i_wdata;
        end
    end

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= mem_ff[i_raddr];
        end
    end

endmodule // eep_mem

/* File: core/eep_top.v */
/*
 * Target-side command logic of a two-wire serial EEPROM: page write,
 * self-timed programming, acknowledge polling and the three read modes.
 * Assumes serial clock and data come from pins outside the reference clock
 * domain, and that the data pin is open drain resolved outside this module.
 */
// Contract
// RL1 - Array is rows of sixteen bytes; a page write stays within one row.
// RL2 - Controller may keep sending data bytes; each is acknowledged on its ninth clock.
// RL3 - STOP after data starts self-timed programming, then return to standby.
// RL4 - After each data byte only the low four address bits increment.
// RL5 - Page write starts at any column; past sixteen bytes the column wraps.
// RL6 - No acknowledge of a valid address while programming; normal acknowledge after.
// RL7 - Controller requests a read with the read/write bit set to one.
// RL8 - Address counter holds last accessed address plus one.
// RL9 - Current read acknowledges, shifts out byte at counter, then increments counter.
// RL10 - Unacknowledged byte then STOP ends a read; device releases data line.
// RL11 - Controller acknowledge after a byte makes the device send the next byte.
// RL12 - Read counter wraps past the top of the array to zero.
// RL13 - Random read is a dummy write of the address, then START and read.
// RL14 - START after dummy write cancels pending programming and keeps the address.
// RL15 - Data falling with clock high is START; rising with clock high is STOP.
// RL16 - Address byte accepted only on fixed code and matching chip-select inputs.
// RL17 - Each received address or data byte is acknowledged by pulling data low.
// RL18 - Write-protect high refuses programming; reads are unaffected.
// RL19 - Self-timed programming ends within five milliseconds.
// RL20 - While programming, ignore traffic other than address polling; never drive data.
`include "eep_defs.vh"

module eep_top #(
    parameter [`EEP_TMR_W-1:0] P_PROG_CYC = `EEP_PROG_CYC
) (
    // Clock and reset.
    input wire i_ref_clk,
    input wire i_rst_b,
    // Two-wire bus pins.
    input wire i_scl,
    input wire i_sda_in,
    output reg o_sda_out,
    output reg o_sda_oe,
    // Straps.
    input wire [2:0] i_chip_select_inputs,
    input wire i_wp,
    // Status.
    output wire o_busy
);

    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_RX = 5'h02;
    localparam [4:0] ST_ACK = 5'h04;
    localparam [4:0] ST_TX = 5'h08;
    localparam [4:0] ST_MACK = 5'h10;

    // Column increment that keeps the row bits.
    function [`EEP_ADDR_W-1:0] col_inc;
        input [`EEP_ADDR_W-1:0] a;
        begin
            col_inc = {a[`EEP_ADDR_W-1:`EEP_COL_W], a[`EEP_COL_W-1:0] + `EEP_CNT_ONE};
        end
    endfunction

    reg scl_meta_ff, scl_ff, scl_d_ff;
    reg sda_meta_ff, sda_ff, sda_d_ff;
    reg wp_meta_ff, wp_ff;
    reg [1:0] cs_meta_ff, cs_ff;
    reg [4:0] state_ff;
    reg [1:0] kind_ff;
    reg [3:0] cnt_ff;
    reg [7:0] rx_ff;
    reg [7:0] tx_ff;
    reg rd_ff;
    reg mack_ff;
    reg [`EEP_ADDR_W-1:0] addr_ff;
    reg [7:0] page_ff [0:`EEP_PAGE_BYTES-1];
    reg [`EEP_PAGE_BYTES-1:0] valid_ff;
    reg [`EEP_ROW_W-1:0] row_ff;
    reg prog_go_ff;
    reg busy_ff;
    reg [4:0] idx_ff;
    reg [`EEP_TMR_W-1:0] tmr_ff;
    reg prog_done_ff;
    wire [7:0] rdata;
    wire scl_rise, scl_fall, start_det, stop_det, dev_match;
    wire [7:0] rx_byte;
    wire mem_we;
    integer i;

    // Two-flop synchronisers on i_scl, i_sda_in, i_wp and i_chip_select_inputs[2:1].
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scl_meta_ff <= 1'b1;
            scl_ff <= 1'b1;
            scl_d_ff <= 1'b1;
            sda_meta_ff <= 1'b1;
            sda_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            wp_meta_ff <= 1'b1;
            wp_ff <= 1'b1;
            cs_meta_ff <= 2'h0;
            cs_ff <= 2'h0;
        end else begin
            scl_meta_ff <= i_scl;
            scl_ff <= scl_meta_ff;
            scl_d_ff <= scl_ff;
            sda_meta_ff <= i_sda_in;
            sda_ff <= sda_meta_ff;
            sda_d_ff <= sda_ff;
            wp_meta_ff <= i_wp;
            wp_ff <= wp_meta_ff;
            cs_meta_ff <= i_chip_select_inputs[2:1];
            cs_ff <= cs_meta_ff;
        end
    end

    assign scl_rise = scl_ff & ~scl_d_ff;
    assign scl_fall = ~scl_ff & scl_d_ff;
    assign start_det = scl_ff & scl_d_ff & sda_d_ff & ~sda_ff; // see RL15
    assign stop_det = scl_ff & scl_d_ff & ~sda_d_ff & sda_ff; // see RL15
    assign rx_byte = rx_ff;
    assign dev_match = (rx_byte[`EEP_CODE_MSB:`EEP_CODE_LSB] == `EEP_DEV_CODE) &&
                       (rx_byte[`EEP_CS_MSB:`EEP_CS_LSB] == cs_ff); // see RL16
    assign o_busy = busy_ff;

    // Bus engine.
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_ff <= ST_IDLE;
            kind_ff <= `EEP_KIND_DEV;
            cnt_ff <= `EEP_CNT_ZERO;
            rx_ff <= 8'h00;
            tx_ff <= 8'h00;
            rd_ff <= 1'b0;
            mack_ff <= 1'b0;
            addr_ff <= {`EEP_ADDR_W{1'b0}};
            valid_ff <= {`EEP_PAGE_BYTES{1'b0}};
            row_ff <= {`EEP_ROW_W{1'b0}};
            prog_go_ff <= 1'b0;
            o_sda_out <= 1'b0;
            o_sda_oe <= 1'b0;
            for (i = 0; i < `EEP_PAGE_BYTES; i = i + 1) begin
                page_ff[i] <= 8'h00;
            end
        end else begin
            prog_go_ff <= 1'b0;
            if (prog_done_ff) begin
                valid_ff <= {`EEP_PAGE_BYTES{1'b0}};
            end
            if (start_det) begin
                state_ff <= ST_RX;
                kind_ff <= `EEP_KIND_DEV;
                cnt_ff <= `EEP_CNT_ZERO;
                o_sda_oe <= 1'b0;
                if (!busy_ff) begin
                    valid_ff <= {`EEP_PAGE_BYTES{1'b0}}; // see RL14, RL13
                end
            end else if (stop_det) begin
                state_ff <= ST_IDLE;
                o_sda_oe <= 1'b0; // see RL10
                if (!busy_ff && (|valid_ff)) begin
                    if (wp_ff) begin
                        valid_ff <= {`EEP_PAGE_BYTES{1'b0}}; // see RL18
                    end else begin
                        prog_go_ff <= 1'b1; // see RL3
                        row_ff <= addr_ff[`EEP_ADDR_W-1:`EEP_COL_W];
                    end
                end
            end else begin
                case (state_ff)
                    ST_IDLE: begin
                        o_sda_oe <= 1'b0;
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            rx_ff <= {rx_ff[6:0], sda_ff};
                            cnt_ff <= cnt_ff + `EEP_CNT_ONE;
                        end else if (scl_fall && cnt_ff == `EEP_BITS_PER_BYTE) begin
                            cnt_ff <= `EEP_CNT_ZERO;
                            if (kind_ff == `EEP_KIND_DEV) begin
                                if (dev_match && !busy_ff) begin // see RL6, RL20
                                    o_sda_oe <= 1'b1; // see RL17
                                    state_ff <= ST_ACK;
                                    rd_ff <= rx_byte[`EEP_RW_BIT]; // see RL7
                                    kind_ff <= `EEP_KIND_WADDR;
                                    if (!rx_byte[`EEP_RW_BIT]) begin
                                        addr_ff[`EEP_ADDR_W-1] <= rx_byte[`EEP_A8_BIT];
                                    end
                                end else begin
                                    state_ff <= ST_IDLE;
                                end
                            end else if (kind_ff == `EEP_KIND_WADDR) begin
                                o_sda_oe <= 1'b1; // see RL17, RL13
                                state_ff <= ST_ACK;
                                addr_ff[`EEP_WADDR_W-1:0] <= rx_byte;
                                kind_ff <= `EEP_KIND_DATA;
                            end else begin
                                o_sda_oe <= 1'b1; // see RL2
                                state_ff <= ST_ACK;
                                page_ff[addr_ff[`EEP_COL_W-1:0]] <= rx_byte; // see RL1
                                valid_ff[addr_ff[`EEP_COL_W-1:0]] <= 1'b1; // see RL5
                                addr_ff <= col_inc(addr_ff); // see RL4, RL8
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            cnt_ff <= `EEP_CNT_ZERO;
                            if (rd_ff) begin
                                tx_ff <= rdata; // see RL9
                                o_sda_oe <= ~rdata[7];
                                state_ff <= ST_TX;
                            end else begin
                                o_sda_oe <= 1'b0;
                                state_ff <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            cnt_ff <= cnt_ff + `EEP_CNT_ONE;
                        end else if (scl_fall) begin
                            if (cnt_ff == `EEP_BITS_PER_BYTE) begin
                                o_sda_oe <= 1'b0;
                                addr_ff <= addr_ff + {{(`EEP_ADDR_W-1){1'b0}}, 1'b1}; // see RL9, RL12
                                state_ff <= ST_MACK;
                                mack_ff <= 1'b0;
                            end else begin
                                o_sda_oe <= ~tx_ff[6];
                                tx_ff <= {tx_ff[6:0], 1'b0};
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            mack_ff <= ~sda_ff;
                        end else if (scl_fall) begin
                            cnt_ff <= `EEP_CNT_ZERO;
                            if (mack_ff) begin
                                tx_ff <= rdata; // see RL11
                                o_sda_oe <= ~rdata[7];
                                state_ff <= ST_TX;
                            end else begin
                                o_sda_oe <= 1'b0; // see RL10
                                state_ff <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                        o_sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Self-timed programming: commit loaded columns while the timer counts out the time.
    assign mem_we = busy_ff && !idx_ff[4] && valid_ff[idx_ff[3:0]];

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_ff <= 1'b0;
            idx_ff <= 5'h00;
            tmr_ff <= {`EEP_TMR_W{1'b0}};
            prog_done_ff <= 1'b0;
        end else begin
            prog_done_ff <= 1'b0;
            if (prog_go_ff) begin
                busy_ff <= 1'b1; // see RL3
                idx_ff <= 5'h00;
                tmr_ff <= {`EEP_TMR_W{1'b0}};
            end else if (busy_ff) begin
                if (!idx_ff[4]) begin
                    idx_ff <= idx_ff + 5'h01;
                end
                if (tmr_ff == P_PROG_CYC - {{(`EEP_TMR_W-1){1'b0}}, 1'b1}) begin
                    busy_ff <= 1'b0; // see RL19
                    prog_done_ff <= 1'b1;
                end else begin
                    tmr_ff <= tmr_ff + {{(`EEP_TMR_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    eep_mem u_mem (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_we(mem_we),
        .i_waddr({row_ff, idx_ff[3:0]}),
        .i_wdata(page_ff[idx_ff[3:0]]),
        .i_raddr(addr_ff),
        .o_rdata(rdata)
    );

endmodule // eep_top

/* File: tb/eep_top_props.sv */
/*
 * Checker of the EEPROM target's pin behaviour at the reference clock.
 * Assumes it is bound to eep_top, whose only clock domain is i_ref_clk.
 */
`include "eep_defs.vh"
module eep_top_props #(
    parameter [`EEP_TMR_W-1:0] P_PROG_CYC = `EEP_PROG_CYC
) (
    // Clock and reset.
    input wire i_ref_clk,
    input wire i_rst_b,
    // Watched pins.
    input wire i_scl,
    input wire i_sda_in,
    input logic o_sda_out,
    input logic o_sda_oe,
    input wire [2:0] i_chip_select_inputs,
    input wire i_wp,
    input wire o_busy
);
    logic scl_ff;
    logic sda_ff;
    logic frame_ff;
    logic [3:0] stop_age_ff;
    logic [`EEP_TMR_W-1:0] busy_cnt_ff;
    wire stop_seen = scl_ff && i_scl && !sda_ff && i_sda_in;
    wire start_seen = scl_ff && i_scl && sda_ff && !i_sda_in;
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            frame_ff <= 1'b0;
            stop_age_ff <= 4'hF;
            busy_cnt_ff <= '0;
        end else begin
            scl_ff <= i_scl;
            sda_ff <= i_sda_in;
            frame_ff <= start_seen ? 1'b1 : (stop_seen ? 1'b0 : frame_ff);
            stop_age_ff <= stop_seen ? 4'h0 : stop_age_ff + {3'h0, stop_age_ff != 4'hF};
            busy_cnt_ff <= o_busy ? busy_cnt_ff + 1'b1 : '0;
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_drive_begin;
        $rose(o_sda_oe);
    endsequence
    sequence s_drive_hold;
        o_sda_oe [*8];
    endsequence
    sequence s_busy_begin;
        $rose(o_busy);
    endsequence
    a_sda_out_low: assert property (o_sda_out == 1'b0)
        else $error("data output not low");
    a_ack_stands: assert property (s_drive_begin |-> s_drive_hold)
        else $error("data pull released too early");
    a_busy_after_stop: assert property (s_busy_begin |-> stop_age_ff <= 4'hA)
        else $error("programming started without stop");
    a_busy_length: assert property ($fell(o_busy) |-> busy_cnt_ff == P_PROG_CYC)
        else $error("programming time wrong");
    a_busy_quiet: assert property (o_busy |-> !o_sda_oe)
        else $error("data driven while programming");
    a_wp_refuse: assert property (s_busy_begin |-> !i_wp)
        else $error("programming while protected");
    a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data changed with clock high");
    a_drive_in_frame: assert property (o_sda_oe |-> frame_ff)
        else $error("data driven outside frame");
endmodule // eep_top_props
bind eep_top eep_top_props #(.P_PROG_CYC(P_PROG_CYC)) u_props (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_scl(i_scl), .i_sda_in(i_sda_in), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .i_chip_select_inputs(i_chip_select_inputs), .i_wp(i_wp),
    .o_busy(o_busy));

/* File: tb/eep_bus_ctl.sv */
/*
 * Model of the two-wire bus controller that makes the serial clock and data.
 * Assumes a pull-up outside resolves the data wire from all open-drain pulls.
 */
module eep_bus_ctl (
    // Bus pins.
    output logic o_scl,
    output logic o_sda_oe,
    input wire logic i_sda
);
    timeunit 1ns;
    timeprecision 10ps;
    localparam realtime QTR = 31.25;
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic start();
        #QTR o_sda_oe = 1'b0;
        #QTR o_scl = 1'b1;
        #QTR o_sda_oe = 1'b1;
        #QTR o_scl = 1'b0;
    endtask
    task automatic stop();
        #QTR o_sda_oe = 1'b1;
        #QTR o_scl = 1'b1;
        #QTR o_sda_oe = 1'b0;
        #QTR;
    endtask
    task automatic bit_cycle(input logic b, output logic r);
        #QTR o_sda_oe = !b;
        #QTR o_scl = 1'b1;
        #QTR r = i_sda;
        #QTR o_scl = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_cycle(d[i], r);
        bit_cycle(1'b1, r);
        ack = !r;
    endtask
    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
        bit_cycle(!ack, r);
    endtask
endmodule // eep_bus_ctl

/* File: tb/test_serial_eeprom_page_write_read.sv */
/*
 * Self-checking bench of the EEPROM target: page writes, polling and reads.
 * Assumes the bus controller model and the checker are compiled before it.
 */
`include "eep_defs.vh"
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
    $display("BAD %s expected %0h seen %0h", nm, e, s); end end
module test_serial_eeprom_page_write_read;
    timeunit 1ns;
    timeprecision 10ps;
    typedef struct {logic [8:0] wa; int wn; logic [8:0] ra; int rn;} eep_row_t;
    logic i_ref_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_wp = 1'b0;
    logic [2:0] i_chip_select_inputs = 3'h5;
    wire scl;
    wire ctl_oe;
    wire o_sda_out;
    wire o_sda_oe;
    wire o_busy;
    wire sda = !(ctl_oe || (o_sda_oe && !o_sda_out));
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [7:0] mdl [0:511];
    eep_row_t rows [3] = '{'{9'h000, 4, 9'h000, 2}, '{9'h1FE, 3, 9'h1FE, 3},
        '{9'h025, 18, 9'h020, 15}};
    eep_top #(.P_PROG_CYC(20'h000C8)) dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
        .i_scl(scl), .i_sda_in(sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
        .i_chip_select_inputs(i_chip_select_inputs), .i_wp(i_wp), .o_busy(o_busy));
    eep_bus_ctl ctl (.o_scl(scl), .o_sda_oe(ctl_oe), .i_sda(sda));
    initial forever #4 i_ref_clk = ~i_ref_clk;
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic dev(input logic [1:0] cs, input logic a8, input logic rw, output logic ack);
        ctl.start();
        ctl.put_byte({`EEP_DEV_CODE, cs, a8, rw}, ack);
    endtask
    task automatic page_write(input logic [8:0] a, input int n, input logic [7:0] s);
        logic ack;
        logic [8:0] p;
        int k;
        p = a;
        dev(i_chip_select_inputs[2:1], a[8], 1'b0, ack);
        `CHK("dev ack", 1'b1, ack)
        ctl.put_byte(a[7:0], ack);
        `CHK("word ack", 1'b1, ack)
        for (k = 0; k < n; k++) begin
            ctl.put_byte(s + 8'(k), ack);
            `CHK("data ack", 1'b1, ack)
            if (!i_wp) mdl[p] = s + 8'(k);
            p[3:0] = p[3:0] + 4'h1;
        end
        ctl.stop();
        repeat (8) @(posedge i_ref_clk);
        `CHK("busy", !i_wp, o_busy)
        if (!i_wp) begin
            dev(i_chip_select_inputs[2:1], a[8], 1'b1, ack);
            `CHK("poll", 1'b0, ack)
            ctl.stop();
            k = 0;
            while (o_busy !== 1'b0 && k < 400) begin
                @(posedge i_ref_clk);
                k++;
            end
            `CHK("busy end", 1'b0, o_busy)
        end
    endtask
    task automatic rd(input logic [8:0] a, input int n, input logic rnd);
        logic ack;
        logic [8:0] p;
        logic [7:0] d;
        p = a;
        if (rnd) begin
            dev(i_chip_select_inputs[2:1], a[8], 1'b0, ack);
            `CHK("dummy ack", 1'b1, ack)
            ctl.put_byte(a[7:0], ack);
            `CHK("dummy word ack", 1'b1, ack)
        end
        dev(i_chip_select_inputs[2:1], 1'b0, 1'b1, ack);
        `CHK("read ack", 1'b1, ack)
        for (int k = 0; k < n; k++) begin
            ctl.get_byte(k < n - 1, d);
            `CHK("read data", mdl[p], d)
            p = p + 9'h001;
        end
        ctl.stop();
        repeat (8) @(posedge i_ref_clk);
        `CHK("no program", 1'b0, o_busy)
    endtask
    initial begin
        logic ack;
        repeat (6) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        `CHK("oe idle", 1'b0, o_sda_oe)
        `CHK("busy idle", 1'b0, o_busy)
        foreach (rows[i]) begin
            page_write(rows[i].wa, rows[i].wn, 8'(i * 8'h31 + 8'h07));
            rd(rows[i].ra, rows[i].rn, 1'b1);
            rd(rows[i].ra + 9'(rows[i].rn), 1, 1'b0);
        end
        dev(2'h1, 1'b0, 1'b1, ack);
        `CHK("wrong select", 1'b0, ack)
        ctl.stop();
        @(posedge i_ref_clk);
        i_wp <= 1'b1;
        page_write(9'h000, 1, 8'hEE);
        @(posedge i_ref_clk);
        i_wp <= 1'b0;
        rd(9'h000, 1, 1'b1);
        @(posedge i_ref_clk);
        i_rst_b <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        rd(9'h000, 1, 1'b0);
        end_of_test();
    end
endmodule // test_serial_eeprom_page_write_read
